// ==== pkg/wgm_map.vh ====
// register map, field positions, mode codes and timing for the web guider mode controller
`ifndef WGM_MAP_VH
`define WGM_MAP_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define WGM_OFF_CTRL 8'h00
`define WGM_OFF_STATUS 8'h04
`define WGM_OFF_MANSPD 8'h08
`define WGM_OFF_CENTER 8'h0C
`define WGM_OFF_OFFSET 8'h10
`define WGM_OFF_RANGE 8'h14
`define WGM_OFF_OSC 8'h18
`define WGM_OFF_GAIN 8'h1C
`define WGM_OFF_THRESH 8'h20
`define WGM_OFF_POS 8'h24
`define WGM_OFF_AUTOSPD 8'h28

// ************************************************************
// control register fields
// ************************************************************
`define WGM_CTRL_MODE 2:0
`define WGM_CTRL_IFEN 3
`define WGM_CTRL_ENSRC 4
`define WGM_CTRL_FIXED 5
`define WGM_CTRL_INTEG 6
`define WGM_CTRL_THREE 7
`define WGM_CTRL_MANL 8
`define WGM_CTRL_MANR 9
`define WGM_CTRL_OSCON 10
`define WGM_CTRL_RESET 16'h0000

// ************************************************************
// operating modes
// ************************************************************
`define WGM_MODE_IDLE 3'h0
`define WGM_MODE_MANUAL 3'h1
`define WGM_MODE_CENTER 3'h2
`define WGM_MODE_AUTO 3'h3
`define WGM_MODE_PARK 3'h4
`define WGM_MODE_EDGE 3'h5

// ************************************************************
// reset values and arithmetic constants
// ************************************************************
`define WGM_MANSPD_RESET 16'h0100
`define WGM_AUTOSPD_RESET 16'h0400
`define WGM_RANGE_RESET 16'h1000
`define WGM_GAIN_RESET 32'h04041010
`define WGM_THRESH_RESET 32'h00200010
`define WGM_OSC_RESET 32'h00100000
`define WGM_HOME_PRESET 16'h0000
`define WGM_GAIN_SHIFT 4
`define WGM_LIM_NUM 3
`define WGM_LIM_DEN_SHIFT 2
`define WGM_INTEG_LIMIT 20'h3FFFF

// ************************************************************
// timing
// ************************************************************
`define WGM_CLK_NS 10
`define WGM_STOP_NS 1000
`define WGM_SPD_WIN_NS 10000
`define WGM_STOP_CYC (`WGM_STOP_NS / `WGM_CLK_NS)
`define WGM_SPD_CYC (`WGM_SPD_WIN_NS / `WGM_CLK_NS)

`endif

// ==== rtl/wgm_osc_gen.v ====
// triangular oscillation generator for the guiding set position
`timescale 1ns/1ns
module wgm_osc_gen #(
	parameter WIDTH = 16
) (
	input wire sys_clk,
	input wire rst_n,
	input wire enable,
	input wire [WIDTH-1:0] stroke,
	input wire [WIDTH-1:0] stepCyc,
	output reg signed [WIDTH-1:0] oscOut
);
	reg [WIDTH-1:0] tickReg;
	reg upReg;
	wire signed [WIDTH:0] top = $signed({1'b0, stroke});

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tickReg <= {WIDTH{1'b0}};
			upReg <= 1'b1;
			oscOut <= {WIDTH{1'b0}};
		end else if (!enable) begin
			tickReg <= {WIDTH{1'b0}};
			upReg <= 1'b1;
			oscOut <= {WIDTH{1'b0}};
		end else if (tickReg >= stepCyc) begin
			tickReg <= {WIDTH{1'b0}};
			// turn at either end of the stroke
			if (upReg && ($signed({oscOut[WIDTH-1], oscOut}) >= top)) begin
				upReg <= 1'b0;
			end else if (!upReg && ($signed({oscOut[WIDTH-1], oscOut}) <= -top)) begin
				upReg <= 1'b1;
			end else if (upReg) begin
				oscOut <= oscOut + 1'b1;
			end else begin
				oscOut <= oscOut - 1'b1;
			end
		end else begin
			tickReg <= tickReg + 1'b1;
		end
	end
endmodule

// ==== rtl/wgm_pid_pwm.v ====
// PID speed controller with pulse-width-modulated power stage command
`timescale 1ns/1ns
`include "wgm_map.vh"
module wgm_pid_pwm #(
	parameter PWM_BITS = 8
) (
	input wire sys_clk,
	input wire rst_n,
	input wire clear,
	input wire sample,
	input wire signed [15:0] speedSet,
	input wire signed [15:0] speedAct,
	input wire [7:0] kp,
	input wire [7:0] ki,
	input wire [7:0] kd,
	output reg pwmOut,
	output reg dirOut
);
	reg signed [19:0] integReg;
	reg signed [16:0] errPrevReg;
	reg signed [15:0] driveReg;
	reg [PWM_BITS-1:0] cntReg;
	wire signed [16:0] err = speedSet - speedAct;
	wire signed [19:0] integSum = integReg + err;
	wire signed [19:0] integLim = $signed(`WGM_INTEG_LIMIT);
	reg signed [35:0] sumWide;
	reg [15:0] mag;
	reg [PWM_BITS-1:0] duty;

	always @* begin
		sumWide = $signed({1'b0, kp}) * err
			+ $signed({1'b0, ki}) * (integReg >>> `WGM_GAIN_SHIFT)
			+ $signed({1'b0, kd}) * (err - errPrevReg);
		sumWide = sumWide >>> `WGM_GAIN_SHIFT;
		mag = driveReg[15] ? 16'h0000 - driveReg : driveReg;
		duty = (mag > {{(16-PWM_BITS){1'b0}}, {PWM_BITS{1'b1}}}) ? {PWM_BITS{1'b1}} :
			mag[PWM_BITS-1:0];
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			integReg <= 20'h00000;
			errPrevReg <= 17'h00000;
			driveReg <= 16'h0000;
			cntReg <= {PWM_BITS{1'b0}};
			pwmOut <= 1'b0;
			dirOut <= 1'b0;
		end else begin
			cntReg <= cntReg + 1'b1;
			pwmOut <= (cntReg < duty);
			dirOut <= driveReg[15];
			if (clear) begin
				integReg <= 20'h00000;
				errPrevReg <= 17'h00000;
				driveReg <= 16'h0000;
			end else if (sample) begin
				// integrator clamped so a stalled actuator cannot wind up
				if (integSum > integLim) begin
					integReg <= integLim;
				end else if (integSum < -integLim) begin
					integReg <= -integLim;
				end else begin
					integReg <= integSum;
				end
				errPrevReg <= err;
				if (sumWide > 36'sd32767) begin
					driveReg <= 16'h7FFF;
				end else if (sumWide < -36'sd32767) begin
					driveReg <= 16'h8001;
				end else begin
					driveReg <= sumWide[15:0];
				end
			end
		end
	end
endmodule

// ==== rtl/wgm_mode_controller.v ====
// operating-mode sequencer, cascaded position loop and APB registers of the web guider
// ************************************************************
// Summary of operation
// - acknowledge each selected mode to the station
// - manual jog left/right at limited speed
// - center: seek switch, preset counter, go center
// - automatic: correct web error only when enabled
// - enable from local pin or interface, auto and edge search
// - signed web offset shifts set position
// - fixed sensors clamp offset to 75 percent
// - oscillation value added to set position
// - fixed sensors keep oscillation within 75 percent
// - park drives slide to outer end
// - edge search tracks edge until mode change
// - P position loop feeds PID speed, PWM
// - integral: web P gives actuator position setpoint
// - support beam sensor follows web edge
// - three-position outputs with threshold and window
// ************************************************************
`timescale 1ns/1ns
`include "wgm_map.vh"
module wgm_mode_controller #(
	parameter BEAM_RANGE = 16'h7FFF,
	parameter PWM_BITS = 8
) (
	input wire sys_clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire signed [15:0] webPos,
	input wire edgeSeen,
	input wire centerSwitch,
	input wire outerEnd,
	input wire encA,
	input wire encB,
	input wire localEnable,
	output wire motorPwm,
	output wire motorDir,
	output reg switchLeft,
	output reg switchRight,
	output reg [2:0] modeAck,
	output reg modeAckPulse
);
	localparam ST_STOP = 1'b0;
	localparam ST_RUN = 1'b1;
	localparam [15:0] STOP_CYC = `WGM_STOP_CYC;
	localparam [15:0] SPD_CYC = `WGM_SPD_CYC;

	// ************************************************************
	// helpers
	// ************************************************************
	function signed [15:0] sat16;
		input signed [31:0] v;
		begin
			if (v > 32'sd32767) begin
				sat16 = 16'h7FFF;
			end else if (v < -32'sd32767) begin
				sat16 = 16'h8001;
			end else begin
				sat16 = v[15:0];
			end
		end
	endfunction

	function signed [15:0] clampMag;
		input signed [15:0] v;
		input [15:0] lim;
		reg signed [16:0] l;
		begin
			l = $signed({2'b00, lim[14:0]});
			// both sides signed, or a negative value would clamp to the positive limit
			if ($signed({v[15], v}) > l) begin
				clampMag = l[15:0];
			end else if ($signed({v[15], v}) < -l) begin
				clampMag = 16'h0000 - l[15:0];
			end else begin
				clampMag = v;
			end
		end
	endfunction

	function signed [15:0] pMul;
		input [7:0] k;
		input signed [15:0] e;
		reg signed [31:0] prod;
		begin
			prod = $signed({1'b0, k}) * e;
			pMul = sat16(prod >>> `WGM_GAIN_SHIFT);
		end
	endfunction

	// ************************************************************
	// registers
	// ************************************************************
	reg [15:0] ctrlReg;
	reg [2:0] modeReqReg;
	reg [15:0] manSpdReg;
	reg signed [15:0] centerReg;
	reg signed [15:0] offsetReg;
	reg [15:0] rangeReg;
	reg [31:0] oscReg;
	reg [31:0] gainReg;
	reg [31:0] threshReg;
	reg [15:0] autoSpdReg;
	reg [2:0] activeModeReg;
	reg stateReg;
	reg [15:0] stopCntReg;
	reg homedReg;
	reg signed [15:0] posReg;
	reg signed [15:0] posLastReg;
	reg signed [15:0] speedReg;
	reg [15:0] spdCntReg;
	reg sampleReg;
	reg encAReg;
	reg encBReg;
	reg guidingReg;

	wire apbAccess = psel & penable & pready;
	wire apbWrite = apbAccess & pwrite;
	wire guiderEn = ctrlReg[`WGM_CTRL_ENSRC] ? ctrlReg[`WGM_CTRL_IFEN] : localEnable;
	wire fixedSensor = ctrlReg[`WGM_CTRL_FIXED];
	wire running = (stateReg == ST_RUN);

	// ************************************************************
	// set position, offset and oscillation
	// ************************************************************
	wire [31:0] range75Wide = rangeReg * `WGM_LIM_NUM;
	wire [15:0] lim75 = range75Wide[17:2];
	wire [15:0] offLim = fixedSensor ? lim75 : BEAM_RANGE;
	wire signed [15:0] oscRaw;
	wire signed [15:0] offEff = clampMag(offsetReg, offLim);
	wire signed [15:0] oscEff = fixedSensor ? clampMag(oscRaw, lim75) : oscRaw;
	wire signed [15:0] setPos = sat16(offEff + oscEff);
	wire signed [15:0] webErr = sat16(setPos - webPos);

	wgm_osc_gen #(
		.WIDTH(16)
	) u_osc (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.enable(ctrlReg[`WGM_CTRL_OSCON] && activeModeReg == `WGM_MODE_AUTO),
		.stroke(oscReg[15:0]),
		.stepCyc(oscReg[31:16]),
		.oscOut(oscRaw)
	);

	// ************************************************************
	// speed setpoint per mode
	// ************************************************************
	reg signed [15:0] speedSet;
	reg signed [15:0] posTarget;
	reg pidClear;
	always @* begin
		speedSet = 16'h0000;
		posTarget = centerReg;
		pidClear = !running || ctrlReg[`WGM_CTRL_THREE];
		if (running) begin
			case (activeModeReg)
				`WGM_MODE_MANUAL: begin
					if (ctrlReg[`WGM_CTRL_MANR] && !ctrlReg[`WGM_CTRL_MANL]) begin
						speedSet = $signed(manSpdReg);
					end else if (ctrlReg[`WGM_CTRL_MANL] && !ctrlReg[`WGM_CTRL_MANR]) begin
						speedSet = 16'h0000 - manSpdReg;
					end
				end
				`WGM_MODE_CENTER: begin
					if (!homedReg) begin
						speedSet = $signed(manSpdReg);
					end else begin
						speedSet = clampMag(pMul(gainReg[31:24], sat16(centerReg - posReg)),
							autoSpdReg);
					end
				end
				`WGM_MODE_AUTO: begin
					if (guiderEn && ctrlReg[`WGM_CTRL_INTEG]) begin
						posTarget = sat16(centerReg + pMul(gainReg[7:0], webErr));
						speedSet = clampMag(pMul(gainReg[31:24], sat16(posTarget - posReg)),
							autoSpdReg);
					end else if (guiderEn) begin
						speedSet = clampMag(pMul(gainReg[7:0], webErr), autoSpdReg);
					end
				end
				`WGM_MODE_PARK: begin
					if (!outerEnd) begin
						speedSet = $signed(autoSpdReg);
					end
				end
				`WGM_MODE_EDGE: begin
					// sensor tracks the edge once seen, otherwise keeps sweeping inward
					if (edgeSeen) begin
						speedSet = clampMag(pMul(gainReg[7:0], sat16(16'h0000 - webPos)),
							autoSpdReg);
					end else begin
						speedSet = 16'h0000 - manSpdReg;
					end
				end
				default: begin
					speedSet = 16'h0000;
				end
			endcase
		end
	end

	wgm_pid_pwm #(
		.PWM_BITS(PWM_BITS)
	) u_pid (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clear(pidClear),
		.sample(sampleReg),
		.speedSet(speedSet),
		.speedAct(speedReg),
		.kp(gainReg[15:8]),
		.ki(gainReg[23:16]),
		.kd(gainReg[23:16]),
		.pwmOut(motorPwm),
		.dirOut(motorDir)
	);

	// ************************************************************
	// mode sequencer
	// ************************************************************
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateReg <= ST_STOP;
			activeModeReg <= `WGM_MODE_IDLE;
			stopCntReg <= 16'h0000;
			modeAck <= `WGM_MODE_IDLE;
			modeAckPulse <= 1'b0;
			homedReg <= 1'b0;
		end else begin
			modeAckPulse <= 1'b0;
			case (stateReg)
				ST_RUN: begin
					if (modeReqReg != activeModeReg) begin
						stateReg <= ST_STOP;
						stopCntReg <= 16'h0000;
					end else if (activeModeReg == `WGM_MODE_CENTER && !homedReg && centerSwitch) begin
						homedReg <= 1'b1;
					end
				end
				ST_STOP: begin
					// motor held still for a settle time before the new sequence starts
					if (stopCntReg >= STOP_CYC - 16'h0001) begin
						stateReg <= ST_RUN;
						activeModeReg <= modeReqReg;
						modeAck <= modeReqReg;
						modeAckPulse <= 1'b1;
						homedReg <= 1'b0;
					end else begin
						stopCntReg <= stopCntReg + 16'h0001;
					end
				end
				default: begin
					stateReg <= ST_STOP;
				end
			endcase
		end
	end

	// ************************************************************
	// encoder position and speed
	// ************************************************************
	wire encStep = encA ^ encAReg ^ encB ^ encBReg;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			encAReg <= 1'b0;
			encBReg <= 1'b0;
			posReg <= 16'h0000;
			posLastReg <= 16'h0000;
			speedReg <= 16'h0000;
			spdCntReg <= 16'h0000;
			sampleReg <= 1'b0;
		end else begin
			encAReg <= encA;
			encBReg <= encB;
			sampleReg <= 1'b0;
			if (running && activeModeReg == `WGM_MODE_CENTER && !homedReg && centerSwitch) begin
				posReg <= `WGM_HOME_PRESET;
			end else if (encStep) begin
				posReg <= (encAReg ^ encB) ? posReg + 16'h0001 : posReg - 16'h0001;
			end
			if (spdCntReg >= SPD_CYC - 16'h0001) begin
				spdCntReg <= 16'h0000;
				speedReg <= posReg - posLastReg;
				posLastReg <= posReg;
				sampleReg <= 1'b1;
			end else begin
				spdCntReg <= spdCntReg + 16'h0001;
			end
		end
	end

	// ************************************************************
	// three-position outputs
	// ************************************************************
	wire signed [16:0] swOn = $signed({1'b0, threshReg[31:16]});
	wire signed [16:0] swWin = $signed({1'b0, threshReg[15:0]});
	wire signed [16:0] errX = {webErr[15], webErr};
	wire threeActive = running && ctrlReg[`WGM_CTRL_THREE] && activeModeReg == `WGM_MODE_AUTO
		&& guiderEn;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			switchLeft <= 1'b0;
			switchRight <= 1'b0;
			guidingReg <= 1'b0;
		end else begin
			guidingReg <= running && activeModeReg == `WGM_MODE_AUTO && guiderEn;
			if (!threeActive || (errX <= swWin && errX >= -swWin)) begin
				switchLeft <= 1'b0;
				switchRight <= 1'b0;
			end else if (errX > swOn) begin
				switchRight <= 1'b1;
				switchLeft <= 1'b0;
			end else if (errX < -swOn) begin
				switchLeft <= 1'b1;
				switchRight <= 1'b0;
			end
		end
	end

	// ************************************************************
	// APB slave
	// ************************************************************
	reg [31:0] rdMux;
	reg mapped;
	always @* begin
		mapped = 1'b1;
		rdMux = 32'h00000000;
		case (paddr)
			`WGM_OFF_CTRL: rdMux = {16'h0000, ctrlReg[15:3], modeReqReg};
			`WGM_OFF_STATUS: rdMux = {26'h0000000, guidingReg, homedReg, stateReg, activeModeReg};
			`WGM_OFF_MANSPD: rdMux = {16'h0000, manSpdReg};
			`WGM_OFF_CENTER: rdMux = {16'h0000, centerReg};
			`WGM_OFF_OFFSET: rdMux = {16'h0000, offsetReg};
			`WGM_OFF_RANGE: rdMux = {16'h0000, rangeReg};
			`WGM_OFF_OSC: rdMux = oscReg;
			`WGM_OFF_GAIN: rdMux = gainReg;
			`WGM_OFF_THRESH: rdMux = threshReg;
			`WGM_OFF_POS: rdMux = {16'h0000, posReg};
			`WGM_OFF_AUTOSPD: rdMux = {16'h0000, autoSpdReg};
			default: mapped = 1'b0;
		endcase
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			// one wait state: answer registered so pready comes from a flop
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			if (psel && penable && !pready && !pwrite) begin
				prdata <= rdMux;
			end
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrlReg <= `WGM_CTRL_RESET;
			modeReqReg <= `WGM_MODE_IDLE;
			manSpdReg <= `WGM_MANSPD_RESET;
			centerReg <= 16'h0000;
			offsetReg <= 16'h0000;
			rangeReg <= `WGM_RANGE_RESET;
			oscReg <= `WGM_OSC_RESET;
			gainReg <= `WGM_GAIN_RESET;
			threshReg <= `WGM_THRESH_RESET;
			autoSpdReg <= `WGM_AUTOSPD_RESET;
		end else begin
			if (running && activeModeReg == `WGM_MODE_EDGE && guiderEn) begin
				modeReqReg <= `WGM_MODE_AUTO;
			end else if (apbWrite && paddr == `WGM_OFF_CTRL) begin
				modeReqReg <= pwdata[`WGM_CTRL_MODE];
			end
			if (apbWrite) begin
				case (paddr)
					`WGM_OFF_CTRL: ctrlReg <= pwdata[15:0];
					`WGM_OFF_MANSPD: manSpdReg <= {1'b0, pwdata[14:0]};
					`WGM_OFF_CENTER: centerReg <= pwdata[15:0];
					`WGM_OFF_OFFSET: offsetReg <= pwdata[15:0];
					`WGM_OFF_RANGE: rangeReg <= pwdata[15:0];
					`WGM_OFF_OSC: oscReg <= pwdata;
					`WGM_OFF_GAIN: gainReg <= pwdata;
					`WGM_OFF_THRESH: threshReg <= pwdata;
					`WGM_OFF_AUTOSPD: autoSpdReg <= {1'b0, pwdata[14:0]};
					default: ctrlReg <= ctrlReg;
				endcase
			end
		end
	end
endmodule

// ==== dv/wgm_far_side.sv ====
// far-side model: actuator with encoder, center switch, outer end switch and edge sensor
`timescale 1ns/1ns
module wgm_far_side (
	input wire sys_clk,
	input wire rst_n,
	input wire motorPwm,
	input wire motorDir,
	input wire signed [15:0] webBias,
	output wire signed [15:0] webPos,
	output wire edgeSeen,
	output wire centerSwitch,
	output wire outerEnd,
	output wire encA,
	output wire encB
);
	// *****
	// actuator
	// *****
	reg signed [15:0] posReg;
	// one count per clock with pwm high, so speed follows the duty
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			posReg <= 16'h0000;
		end else if (motorPwm) begin
			posReg <= motorDir ? posReg - 16'h0001 : posReg + 16'h0001;
		end
	end
	assign encA = posReg[1];
	assign encB = posReg[1] ^ posReg[0];
	assign centerSwitch = posReg >= 16'sh0020;
	assign outerEnd = posReg >= 16'sh0080;
	// sensor on a fixed frame: web position is set by the bench alone
	assign webPos = webBias;
	assign edgeSeen = (webBias < 16'sh0008) && (webBias > -16'sh0008);
endmodule

// ==== dv/wgm_props.sv ====
// port checker for the web guider mode controller
`timescale 1ns/1ns
`include "wgm_map.vh"
module wgm_props (
	input wire sys_clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire motorPwm,
	input wire switchLeft,
	input wire switchRight,
	input wire [2:0] modeAck,
	input wire modeAckPulse
);
	// *****
	// assertions
	// *****
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence ctrl_change;
		psel && penable && pready && pwrite && paddr == `WGM_OFF_CTRL && pwdata[2:0] != modeAck;
	endsequence
	sequence stop_then_ack;
		(!modeAckPulse) [*8] ##[85:100] modeAckPulse;
	endsequence
	a_ack_after_stop: assert property (ctrl_change |=> stop_then_ack)
		else $error("mode acknowledge not after stop phase");
	a_stop_no_drive: assert property (ctrl_change |-> ##4 (!motorPwm) [*8])
		else $error("motor driven during stop phase");
	a_ack_pulse_one: assert property (modeAckPulse |=> !modeAckPulse)
		else $error("acknowledge pulse longer than one cycle");
	a_ack_held: assert property (!modeAckPulse |-> $stable(modeAck))
		else $error("acknowledged mode changed without pulse");
	a_ack_legal: assert property (modeAck <= `WGM_MODE_EDGE)
		else $error("acknowledged mode not defined");
	a_switch_excl: assert property (!(switchLeft && switchRight))
		else $error("both direction outputs set");
	a_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
		else $error("ready not after one wait state");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_unmapped: assert property (pready && paddr > `WGM_OFF_AUTOSPD |-> pslverr)
		else $error("unmapped access without error");
	a_err_mapped: assert property (pready && paddr <= `WGM_OFF_AUTOSPD && paddr[1:0] == 2'h0
		|-> !pslverr)
		else $error("mapped access flagged");
endmodule
bind wgm_mode_controller wgm_props u_wgm_props (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .motorPwm(motorPwm), .switchLeft(switchLeft),
	.switchRight(switchRight), .modeAck(modeAck), .modeAckPulse(modeAckPulse));

// ==== dv/tb_web_guider_mode_controller.sv ====
// self-checking bench for the web guider mode controller
`timescale 1ns/1ns
`include "wgm_map.vh"
module tb_web_guider_mode_controller;
	logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, localEnable = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, rd;
	logic signed [15:0] webBias = 16'h0000;
	wire [31:0] prdata;
	wire pready, pslverr, motorPwm, motorDir, switchLeft, switchRight, modeAckPulse;
	wire edgeSeen, centerSwitch, outerEnd, encA, encB;
	wire [2:0] modeAck;
	wire signed [15:0] webPos;
	logic errSeen, side;
	integer err_total = 0, comparisons = 0, i;
	localparam [31:0] MANL = 32'h1 << `WGM_CTRL_MANL, MANR = 32'h1 << `WGM_CTRL_MANR;
	localparam [31:0] IFEN = 32'h1 << `WGM_CTRL_IFEN, ENSRC = 32'h1 << `WGM_CTRL_ENSRC;
	localparam [31:0] FIXED = 32'h1 << `WGM_CTRL_FIXED, INTEG = 32'h1 << `WGM_CTRL_INTEG;
	localparam [31:0] THREE = 32'h1 << `WGM_CTRL_THREE, OSCON = 32'h1 << `WGM_CTRL_OSCON;
	logic [7:0] rAddr [0:6] = '{`WGM_OFF_CTRL, `WGM_OFF_MANSPD, `WGM_OFF_RANGE, `WGM_OFF_OSC,
		`WGM_OFF_GAIN, `WGM_OFF_THRESH, `WGM_OFF_AUTOSPD};
	logic [31:0] rVal [0:6] = '{`WGM_CTRL_RESET, `WGM_MANSPD_RESET, `WGM_RANGE_RESET,
		`WGM_OSC_RESET, `WGM_GAIN_RESET, `WGM_THRESH_RESET, `WGM_AUTOSPD_RESET};
	wgm_mode_controller u_wgm_mode_controller (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .webPos(webPos), .edgeSeen(edgeSeen),
		.centerSwitch(centerSwitch), .outerEnd(outerEnd), .encA(encA), .encB(encB),
		.localEnable(localEnable), .motorPwm(motorPwm), .motorDir(motorDir),
		.switchLeft(switchLeft), .switchRight(switchRight), .modeAck(modeAck),
		.modeAckPulse(modeAckPulse));
	wgm_far_side u_wgm_far_side (.sys_clk(sys_clk), .rst_n(rst_n), .motorPwm(motorPwm),
		.motorDir(motorDir), .webBias(webBias), .webPos(webPos), .edgeSeen(edgeSeen),
		.centerSwitch(centerSwitch), .outerEnd(outerEnd), .encA(encA), .encB(encB));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	// *****
	// tasks
	// *****
	task report_and_stop;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, err_total);
			if (err_total == 0 && comparisons > 0) begin
				$display("Regression OK");
			end else begin
				$display("Regression broken");
			end
			$finish;
		end
	endtask
	task check(input [31:0] seen, input [31:0] want);
		begin
			comparisons = comparisons + 1;
			if (seen !== want) begin
				err_total = err_total + 1;
				$display("ERROR at %0t seen %h expected %h", $time, seen, want);
			end
		end
	endtask
	// the request is held until pready is sampled high and released at that same edge
	task apb(input logic wr, input [7:0] addr, input [31:0] data);
		integer n;
		begin
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= addr;
			pwdata <= data;
			@(posedge sys_clk);
			penable <= 1'b1;
			n = 0;
			@(posedge sys_clk);
			while (pready !== 1'b1 && n < 20) begin
				@(posedge sys_clk);
				n = n + 1;
			end
			check(n < 20, 1'b1);
			if (n >= 20) begin
				report_and_stop;
			end
			rd = prdata;
			errSeen = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge sys_clk);
		end
	endtask
	function logic cond(input integer w);
		case (w)
			0: cond = modeAckPulse;
			1: cond = outerEnd;
			2: cond = motorPwm & ~motorDir;
			3: cond = switchLeft | switchRight;
			4: cond = modeAck == `WGM_MODE_AUTO;
			5: cond = motorPwm & motorDir;
			6: cond = centerSwitch;
			7: cond = (switchLeft | switchRight) && switchLeft !== side;
			default: cond = ~(switchLeft | switchRight);
		endcase
	endfunction
	// a miss that was expected to hit ends the run at once
	task wait_on(input integer w, input integer lim, input logic want);
		integer n;
		begin
			n = 0;
			@(posedge sys_clk);
			while (cond(w) !== 1'b1 && n < lim) begin
				@(posedge sys_clk);
				n = n + 1;
			end
			check(n < lim, want);
			if (want && n >= lim) begin
				report_and_stop;
			end
		end
	endtask
	task set_mode(input [31:0] v);
		begin
			apb(1'b1, `WGM_OFF_CTRL, v);
			wait_on(0, 300, 1'b1);
			check(modeAck, v[2:0]);
		end
	endtask
	task poll_status(input integer b, input logic want);
		integer n;
		begin
			n = 0;
			apb(1'b0, `WGM_OFF_STATUS, 32'h00000000);
			while (rd[b] !== want && n < 50) begin
				apb(1'b0, `WGM_OFF_STATUS, 32'h00000000);
				n = n + 1;
			end
			check(rd[b], want);
			if (rd[b] !== want) begin
				report_and_stop;
			end
		end
	endtask
	// *****
	// main sequence
	// *****
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		wait_on(0, 300, 1'b1);
		check(modeAck, `WGM_MODE_IDLE);
		for (i = 0; i < 7; i = i + 1) begin
			apb(1'b0, rAddr[i], 32'h00000000);
			check(rd, rVal[i]);
		end
		apb(1'b0, 8'h40, 32'h00000000);
		check(rd, 32'h00000000);
		check(errSeen, 1'b1);
		apb(1'b1, `WGM_OFF_STATUS, 32'h00000007);
		apb(1'b0, `WGM_OFF_STATUS, 32'h00000000);
		check(rd[2:0], `WGM_MODE_IDLE);
		for (i = 5; i >= 0; i = i - 1) begin
			set_mode(i);
			apb(1'b0, `WGM_OFF_STATUS, 32'h00000000);
			check(rd[2:0], i);
		end
		// speed is sampled only once per window, so a drive change can take a full window
		set_mode(`WGM_MODE_MANUAL | MANR);
		wait_on(2, 1500, 1'b1);
		apb(1'b1, `WGM_OFF_CTRL, `WGM_MODE_MANUAL | MANL);
		wait_on(5, 1500, 1'b1);
		set_mode(`WGM_MODE_CENTER);
		wait_on(6, 4000, 1'b1);
		poll_status(4, 1'b1);
		set_mode(`WGM_MODE_AUTO);
		poll_status(5, 1'b0);
		localEnable <= 1'b1;
		poll_status(5, 1'b1);
		localEnable <= 1'b0;
		apb(1'b1, `WGM_OFF_CTRL, `WGM_MODE_AUTO | ENSRC | IFEN);
		poll_status(5, 1'b1);
		// web above the set position: actuator moves negative
		webBias <= 16'h0200;
		wait_on(5, 2000, 1'b1);
		apb(1'b1, `WGM_OFF_CTRL, `WGM_MODE_AUTO | ENSRC | IFEN | INTEG);
		webBias <= 16'hFE00;
		wait_on(2, 2000, 1'b1);
		apb(1'b1, `WGM_OFF_CTRL, `WGM_MODE_AUTO | ENSRC);
		localEnable <= 1'b1;
		poll_status(5, 1'b0);
		webBias <= 16'h0000;
		apb(1'b1, `WGM_OFF_THRESH, 32'h00400010);
		apb(1'b1, `WGM_OFF_RANGE, 32'h00000040);
		apb(1'b1, `WGM_OFF_OFFSET, 32'h00000100);
		apb(1'b1, `WGM_OFF_CTRL, `WGM_MODE_AUTO | THREE | FIXED);
		wait_on(3, 300, 1'b0);
		apb(1'b1, `WGM_OFF_CTRL, `WGM_MODE_AUTO | THREE);
		wait_on(3, 300, 1'b1);
		side = switchLeft;
		apb(1'b1, `WGM_OFF_OFFSET, 32'h0000FF00);
		wait_on(7, 300, 1'b1);
		apb(1'b1, `WGM_OFF_OFFSET, 32'h00000000);
		wait_on(8, 300, 1'b1);
		apb(1'b1, `WGM_OFF_OSC, 32'h00010080);
		apb(1'b1, `WGM_OFF_CTRL, `WGM_MODE_AUTO | THREE | OSCON | FIXED);
		wait_on(3, 2000, 1'b0);
		apb(1'b1, `WGM_OFF_CTRL, `WGM_MODE_AUTO | THREE | OSCON);
		wait_on(3, 2000, 1'b1);
		set_mode(`WGM_MODE_PARK);
		wait_on(1, 8000, 1'b1);
		localEnable <= 1'b0;
		webBias <= 16'h0300;
		set_mode(`WGM_MODE_EDGE);
		webBias <= 16'h0000;
		localEnable <= 1'b1;
		wait_on(4, 500, 1'b1);
		report_and_stop;
	end
endmodule
